// *** fifo_control_pkg.sv ***
package fifo_control_pkg;

  // ----------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------
  localparam int unsigned    DATA_W         = 8;
  localparam int unsigned    FIFO_DEPTH     = 64;
  localparam int unsigned    PTR_W          = 6;
  localparam int unsigned    CNT_W          = 7;
  localparam int unsigned    BIT_ENABLE     = 0;
  localparam int unsigned    BIT_RX_CLEAR   = 1;
  localparam int unsigned    BIT_TX_CLEAR   = 2;
  localparam int unsigned    BIT_DMA_MODE   = 3;
  localparam int unsigned    TX_TRIG_LSB    = 4;
  localparam int unsigned    RX_TRIG_LSB    = 6;
  localparam logic [1:0]     TRIG_RESET     = 2'h0;
  localparam logic [PTR_W-1:0] PTR_ZERO     = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO     = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE      = 7'h01;

  // ----------------------------------------------------------------
  // Trigger level tables
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] RX_LVL_0     = 7'h08;
  localparam logic [CNT_W-1:0] RX_LVL_1     = 7'h10;
  localparam logic [CNT_W-1:0] RX_LVL_2     = 7'h38;
  localparam logic [CNT_W-1:0] RX_LVL_3     = 7'h3C;
  localparam logic [CNT_W-1:0] TX_LVL_0     = 7'h08;
  localparam logic [CNT_W-1:0] TX_LVL_1     = 7'h10;
  localparam logic [CNT_W-1:0] TX_LVL_2     = 7'h20;
  localparam logic [CNT_W-1:0] TX_LVL_3     = 7'h38;

  // Decoded control settings held by the top; the queues only receive the enable bit.
  typedef struct packed {
    logic       fifo_enable;
    logic       dma_mode;
    logic [1:0] receive_threshold_select;
    logic [1:0] tx_threshold_select;
  } ctrl_s;

endpackage : fifo_control_pkg

// *** char_queue.sv ***
`timescale 1ns/1ps
// Character queue with synchronous clear; single-entry mode when disabled.
module char_queue
  import fifo_control_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              clear,
  input  wire logic              enable,
  input  wire logic              push,
  input  wire logic [DATA_W-1:0] push_data,
  input  wire logic              pop,
  output logic      [DATA_W-1:0] pop_data,
  output logic      [CNT_W-1:0]  count
);

  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic [DATA_W-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0]  wr_reg, wr_next, rd_reg, rd_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic              do_push, do_pop;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Clear only resets pointers and count; shifters live outside and are untouched.
  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    do_pop   = pop && (cnt_reg != CNT_ZERO);
    do_push  = push && (!enable || cnt_reg != CNT_WIDTH_FULL());
    if (clear) begin
      wr_next  = PTR_ZERO;
      rd_next  = PTR_ZERO;
      cnt_next = CNT_ZERO;
    end else if (!enable) begin
      // Entry zero holds one character; a new one overwrites an unread one.
      rd_next = PTR_ZERO;
      if (do_push) begin
        mem_next[0] = push_data;
        cnt_next    = CNT_ONE;
      end else if (do_pop) begin
        cnt_next = CNT_ZERO;
      end
      // The write pointer sits past a held character so that enabling the
      // queue later does not overwrite it with the next push.
      wr_next = (cnt_next == CNT_ZERO) ? PTR_ZERO : PTR_W'(CNT_ONE);
    end else begin
      if (do_push) begin
        mem_next[wr_reg] = push_data;
        wr_next          = wr_reg + 6'h01;
      end
      if (do_pop) begin
        rd_next = rd_reg + 6'h01;
      end
      cnt_next = cnt_reg + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  function automatic logic [CNT_W-1:0] CNT_WIDTH_FULL();
    return CNT_W'(DEPTH);
  endfunction : CNT_WIDTH_FULL

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Storage has no reset; only the bookkeeping does.
  always_ff @(posedge clock) begin
    mem_reg <= mem_next;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_reg  <= PTR_ZERO;
      rd_reg  <= PTR_ZERO;
      cnt_reg <= CNT_ZERO;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  assign pop_data = mem_reg[rd_reg];
  assign count    = cnt_reg;

endmodule : char_queue

// *** trigger_compare.sv ***
`timescale 1ns/1ps
// Threshold lookup and comparison for one queue direction.
module trigger_compare
  import fifo_control_pkg::*;
#(
  parameter bit IS_TX = 1'b0
) (
  input  wire logic [1:0]       select,
  input  wire logic [CNT_W-1:0] level,
  output logic                  hit
);

  // ----------------------------------------------------------------
  // Level tables
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] threshold(input logic tx, input logic [1:0] sel);
    unique case (sel)
      2'h0: return tx ? TX_LVL_0 : RX_LVL_0;
      2'h1: return tx ? TX_LVL_1 : RX_LVL_1;
      2'h2: return tx ? TX_LVL_2 : RX_LVL_2;
      2'h3: return tx ? TX_LVL_3 : RX_LVL_3;
    endcase
  endfunction : threshold

  // Level is the stored count for receive, free spaces for transmit.
  always_comb begin
    hit = level >= threshold(IS_TX, select);
  end

endmodule : trigger_compare

// *** uart_fifo_control.sv ***
`timescale 1ns/1ps
module uart_fifo_control
  import fifo_control_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ctrl_write,
  input  wire logic [DATA_W-1:0] ctrl_wdata,
  input  wire logic              enhanced_enable,
  input  wire logic              tx_push,
  input  wire logic [DATA_W-1:0] tx_push_data,
  input  wire logic              tx_pop,
  input  wire logic              rx_push,
  input  wire logic [DATA_W-1:0] rx_push_data,
  input  wire logic              rx_pop,
  output logic      [DATA_W-1:0] tx_data_reg,
  output logic      [DATA_W-1:0] rx_data_reg,
  output logic      [CNT_W-1:0]  tx_count_reg,
  output logic      [CNT_W-1:0]  rx_count_reg,
  output logic                   fifo_enable_reg,
  output logic                   dma_mode_reg,
  output logic                   tx_clear_reg,
  output logic                   rx_clear_reg,
  output logic                   rx_trigger_reg,
  output logic                   tx_trigger_reg,
  output logic                   rx_ready_n_reg,
  output logic                   tx_ready_n_reg
);

  // ----------------------------------------------------------------
  // Control register decode
  // ----------------------------------------------------------------
  ctrl_s ctrl_reg, ctrl_next;
  logic  tx_clear_next, rx_clear_next;

  // There is no read path here: the host-facing mux returns a different
  // register at this address, so the settings cannot be read back.
  always_comb begin
    ctrl_next     = ctrl_reg;
    tx_clear_next = 1'b0;
    rx_clear_next = 1'b0;
    if (ctrl_write) begin
      ctrl_next.fifo_enable              = ctrl_wdata[BIT_ENABLE];
      ctrl_next.dma_mode                 = ctrl_wdata[BIT_DMA_MODE];
      ctrl_next.receive_threshold_select = ctrl_wdata[RX_TRIG_LSB +: 2];
      if (enhanced_enable) begin
        ctrl_next.tx_threshold_select = ctrl_wdata[TX_TRIG_LSB +: 2];
      end
      tx_clear_next = ctrl_wdata[BIT_TX_CLEAR];
      rx_clear_next = ctrl_wdata[BIT_RX_CLEAR];
    end
  end

  // Clear pulses last one cycle; the queue empties on the edge that ends the pulse.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg     <= '{fifo_enable: 1'b0, dma_mode: 1'b0,
                        receive_threshold_select: TRIG_RESET,
                        tx_threshold_select: TRIG_RESET};
      tx_clear_reg <= 1'b0;
      rx_clear_reg <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      tx_clear_reg <= tx_clear_next;
      rx_clear_reg <= rx_clear_next;
    end
  end

  // ----------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] tx_head, rx_head;
  logic [CNT_W-1:0]  tx_cnt, rx_cnt;
  logic [CNT_W-1:0]  tx_free;
  logic [1:0]        tx_sel_eff;
  logic              rx_hit, tx_hit;

  // The shifters sit outside this block, so a clear cannot reach them.
  char_queue #(.DEPTH(FIFO_DEPTH)) u_tx_queue (
    .clock     (clock),
    .rst       (rst),
    .clear     (tx_clear_reg),
    .enable    (ctrl_reg.fifo_enable),
    .push      (tx_push),
    .push_data (tx_push_data),
    .pop       (tx_pop),
    .pop_data  (tx_head),
    .count     (tx_cnt)
  );

  char_queue #(.DEPTH(FIFO_DEPTH)) u_rx_queue (
    .clock     (clock),
    .rst       (rst),
    .clear     (rx_clear_reg),
    .enable    (ctrl_reg.fifo_enable),
    .push      (rx_push),
    .push_data (rx_push_data),
    .pop       (rx_pop),
    .pop_data  (rx_head),
    .count     (rx_cnt)
  );

  // ----------------------------------------------------------------
  // Trigger levels
  // ----------------------------------------------------------------
  // The transmit field only applies while enhanced functions are on;
  // otherwise the default level is used.
  always_comb begin
    tx_free    = CNT_W'(FIFO_DEPTH) - tx_cnt;
    tx_sel_eff = enhanced_enable ? ctrl_reg.tx_threshold_select : TRIG_RESET;
  end

  trigger_compare #(.IS_TX(1'b0)) u_rx_trig (
    .select (ctrl_reg.receive_threshold_select),
    .level  (rx_cnt),
    .hit    (rx_hit)
  );

  trigger_compare #(.IS_TX(1'b1)) u_tx_trig (
    .select (tx_sel_eff),
    .level  (tx_free),
    .hit    (tx_hit)
  );

  // ----------------------------------------------------------------
  // DMA ready and registered outputs
  // ----------------------------------------------------------------
  logic rx_ready_n_next, tx_ready_n_next;

  // Mode 0 signals single characters; mode 1 signals trigger-level blocks.
  // Mode 1 ignores the enable bit since disabled queues hold one entry anyway.
  always_comb begin
    if (ctrl_reg.dma_mode) begin
      rx_ready_n_next = !rx_hit;
      tx_ready_n_next = !tx_hit;
    end else begin
      rx_ready_n_next = (rx_cnt == CNT_ZERO);
      tx_ready_n_next = (tx_cnt != CNT_ZERO);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_data_reg     <= '0;
      rx_data_reg     <= '0;
      tx_count_reg    <= CNT_ZERO;
      rx_count_reg    <= CNT_ZERO;
      rx_trigger_reg  <= 1'b0;
      tx_trigger_reg  <= 1'b0;
      rx_ready_n_reg  <= 1'b1;
      tx_ready_n_reg  <= 1'b1;
    end else begin
      tx_data_reg     <= tx_head;
      rx_data_reg     <= rx_head;
      tx_count_reg    <= tx_cnt;
      rx_count_reg    <= rx_cnt;
      rx_trigger_reg  <= rx_hit;
      tx_trigger_reg  <= tx_hit;
      rx_ready_n_reg  <= rx_ready_n_next;
      tx_ready_n_reg  <= tx_ready_n_next;
    end
  end

  assign fifo_enable_reg = ctrl_reg.fifo_enable;
  assign dma_mode_reg    = ctrl_reg.dma_mode;

endmodule : uart_fifo_control

// *** fifo_control_chk_sva.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// Control register checker.
// ------------------------------------------------
module fifo_control_chk
  import fifo_control_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              ctrl_write,
  input wire logic [DATA_W-1:0] ctrl_wdata,
  input wire logic              tx_push,
  input wire logic              rx_push,
  input wire logic [CNT_W-1:0]  tx_count_reg,
  input wire logic [CNT_W-1:0]  rx_count_reg,
  input wire logic              fifo_enable_reg,
  input wire logic              dma_mode_reg,
  input wire logic              tx_clear_reg,
  input wire logic              rx_clear_reg,
  input wire logic              rx_trigger_reg,
  input wire logic              tx_trigger_reg,
  input wire logic              rx_ready_n_reg,
  input wire logic              tx_ready_n_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // A push in the cycle after the pulse would refill the queue, so it is excluded.
  sequence s_tx_clr; tx_clear_reg ##1 !tx_push; endsequence
  sequence s_rx_clr; rx_clear_reg ##1 !rx_push; endsequence

  AST_TX_CLR: assert property (ctrl_write && ctrl_wdata[BIT_TX_CLEAR] |=> tx_clear_reg)
    else $error("tx clear pulse missing");
  AST_RX_CLR: assert property (ctrl_write && ctrl_wdata[BIT_RX_CLEAR] |=> rx_clear_reg)
    else $error("rx clear pulse missing");
  AST_TX_SELF: assert property (tx_clear_reg && !(ctrl_write && ctrl_wdata[BIT_TX_CLEAR]) |=> !tx_clear_reg)
    else $error("tx clear stuck");
  AST_RX_SELF: assert property (rx_clear_reg && !(ctrl_write && ctrl_wdata[BIT_RX_CLEAR]) |=> !rx_clear_reg)
    else $error("rx clear stuck");
  AST_TX_EMPTY: assert property (s_tx_clr |=> tx_count_reg == CNT_ZERO)
    else $error("tx count not emptied");
  AST_RX_EMPTY: assert property (s_rx_clr |=> rx_count_reg == CNT_ZERO)
    else $error("rx count not emptied");
  AST_ENABLE: assert property (ctrl_write |=> fifo_enable_reg == $past(ctrl_wdata[BIT_ENABLE]))
    else $error("enable not taken");
  AST_DMA: assert property (ctrl_write |=> dma_mode_reg == $past(ctrl_wdata[BIT_DMA_MODE]))
    else $error("dma mode not taken");
  AST_HOLD: assert property (!ctrl_write |=> $stable(fifo_enable_reg) && $stable(dma_mode_reg))
    else $error("settings moved without write");

  // Ready outputs follow the mode that stood one edge earlier; the edge after reset is skipped.
  sequence s_mode0; !$past(rst) && !$past(dma_mode_reg); endsequence
  sequence s_mode1; !$past(rst) && $past(dma_mode_reg); endsequence

  AST_RDY0_RX: assert property (s_mode0 |-> rx_ready_n_reg == (rx_count_reg == CNT_ZERO))
    else $error("rx ready wrong in dma mode 0");
  AST_RDY0_TX: assert property (s_mode0 |-> tx_ready_n_reg == (tx_count_reg != CNT_ZERO))
    else $error("tx ready wrong in dma mode 0");
  AST_RDY1_RX: assert property (s_mode1 |-> rx_ready_n_reg == !rx_trigger_reg)
    else $error("rx ready wrong in dma mode 1");
  AST_RDY1_TX: assert property (s_mode1 |-> tx_ready_n_reg == !tx_trigger_reg)
    else $error("tx ready wrong in dma mode 1");
endmodule : fifo_control_chk

bind uart_fifo_control fifo_control_chk i_chk (.clock(clock), .rst(rst), .ctrl_write(ctrl_write),
  .ctrl_wdata(ctrl_wdata), .tx_push(tx_push), .rx_push(rx_push), .tx_count_reg(tx_count_reg),
  .rx_count_reg(rx_count_reg), .fifo_enable_reg(fifo_enable_reg), .dma_mode_reg(dma_mode_reg),
  .tx_clear_reg(tx_clear_reg), .rx_clear_reg(rx_clear_reg), .rx_trigger_reg(rx_trigger_reg),
  .tx_trigger_reg(tx_trigger_reg), .rx_ready_n_reg(rx_ready_n_reg), .tx_ready_n_reg(tx_ready_n_reg));

// *** host_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// Host side of the control register.
// ------------------------------------------------
module host_model
  import fifo_control_pkg::*;
(
  input  wire logic              clock,
  output logic                   ctrl_write,
  output logic      [DATA_W-1:0] ctrl_wdata
);
  // Idle bus at time zero.
  initial begin
    ctrl_write = 1'b0;
    ctrl_wdata = 8'h00;
  end

  // Write only; the register cannot be read back, so no read task exists.
  task automatic write_ctrl(input logic [DATA_W-1:0] value);
    @(posedge clock);
    ctrl_write <= 1'b1;
    ctrl_wdata <= value;
    @(posedge clock);
    ctrl_write <= 1'b0;
    ctrl_wdata <= ~value; // Released data must not look valid.
  endtask : write_ctrl
endmodule : host_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import fifo_control_pkg::*;
  logic clock, rst, ctrl_write, enhanced_enable, tx_push, rx_push;
  logic [DATA_W-1:0] ctrl_wdata, tx_push_data, rx_push_data, tx_data_reg, rx_data_reg;
  logic [CNT_W-1:0] tx_count_reg, rx_count_reg;
  logic fifo_enable_reg, dma_mode_reg, tx_clear_reg, rx_clear_reg;
  logic rx_trigger_reg, tx_trigger_reg, rx_ready_n_reg, tx_ready_n_reg;
  logic tx_pop, rx_pop;
  int error_cnt, total_checks;

  host_model i_host (.clock(clock), .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata));

  uart_fifo_control i_dut (.clock(clock), .rst(rst), .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata),
    .enhanced_enable(enhanced_enable), .tx_push(tx_push), .tx_push_data(tx_push_data), .tx_pop(tx_pop),
    .rx_push(rx_push), .rx_push_data(rx_push_data), .rx_pop(rx_pop), .tx_data_reg(tx_data_reg),
    .rx_data_reg(rx_data_reg), .tx_count_reg(tx_count_reg), .rx_count_reg(rx_count_reg),
    .fifo_enable_reg(fifo_enable_reg), .dma_mode_reg(dma_mode_reg), .tx_clear_reg(tx_clear_reg),
    .rx_clear_reg(rx_clear_reg), .rx_trigger_reg(rx_trigger_reg), .tx_trigger_reg(tx_trigger_reg),
    .rx_ready_n_reg(rx_ready_n_reg), .tx_ready_n_reg(tx_ready_n_reg));

  // ------------------------------------------------
  // Helpers.
  // ------------------------------------------------
  task ck(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : ck

  // Sample 1 ns after an edge so that its updates have landed.
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task wr(input logic [7:0] v);
    i_host.write_ctrl(v);
    #1;
  endtask : wr

  // Back-to-back pushes, one character per edge.
  task push(input bit tx, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      if (tx) begin
        tx_push <= 1'b1;
        tx_push_data <= 8'(i);
      end else begin
        rx_push <= 1'b1;
        rx_push_data <= 8'(i);
      end
    end
    @(posedge clock);
    tx_push <= 1'b0;
    rx_push <= 1'b0;
  endtask : push

  // One-cycle pop strobe; the head output follows one edge later.
  task pop(input bit tx);
    @(posedge clock);
    if (tx) begin
      tx_pop <= 1'b1;
    end else begin
      rx_pop <= 1'b1;
    end
    @(posedge clock);
    tx_pop <= 1'b0;
    rx_pop <= 1'b0;
  endtask : pop

  // ------------------------------------------------
  // Scenarios.
  // ------------------------------------------------
  task t_enable;
    wr(8'h07);
    ck(8'({tx_clear_reg, rx_clear_reg, fifo_enable_reg}), 8'h07, "clear pulse");
    step(1);
    ck(8'({tx_clear_reg, rx_clear_reg}), 8'h00, "clear not self ended");
    step(3);
    ck(8'({tx_ready_n_reg, rx_ready_n_reg}), 8'h01, "dma mode 0 ready");
    wr(8'h08);
    ck(8'({fifo_enable_reg, dma_mode_reg}), 8'h01, "disable or dma 1");
    wr(8'h09);
    ck(8'({fifo_enable_reg, dma_mode_reg}), 8'h03, "enable with dma 1");
  endtask : t_enable

  task t_rx_trig;
    logic [7:0] lvl [4] = '{8'h08, 8'h10, 8'h38, 8'h3C};
    for (int c = 0; c < 4; c++) begin
      wr(8'h07 | (8'(c) << 6));
      push(1'b0, int'(lvl[c]) - 1);
      step(4);
      ck(8'(rx_trigger_reg), 8'h00, "rx trigger early");
      push(1'b0, 1);
      step(4);
      ck(8'(rx_trigger_reg), 8'h01, "rx trigger missing");
    end
    wr(8'h03);
    step(3);
    ck(8'(rx_count_reg), 8'h00, "rx not cleared");
  endtask : t_rx_trig

  task t_tx_trig;
    logic [7:0] lvl [4] = '{8'h08, 8'h10, 8'h20, 8'h38};
    @(posedge clock);
    enhanced_enable <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h07 | (8'(c) << 4));
      push(1'b1, 64 - int'(lvl[c]));
      step(4);
      ck(8'(tx_trigger_reg), 8'h01, "tx trigger missing");
      push(1'b1, 1);
      step(4);
      ck(8'(tx_trigger_reg), 8'h00, "tx trigger late");
    end
  endtask : t_tx_trig

  // Code 11 is stored from before; a gated write of 00 must not replace it.
  // While gated the level is 8, once enhanced functions return it is 56.
  task t_gated;
    @(posedge clock);
    enhanced_enable <= 1'b0;
    wr(8'h07);
    push(1'b1, 56);
    step(4);
    ck(8'(tx_trigger_reg), 8'h01, "tx field applied while gated");
    @(posedge clock);
    enhanced_enable <= 1'b1;
    step(4);
    ck(8'(tx_trigger_reg), 8'h00, "tx field taken while gated");
  endtask : t_gated

  task t_disabled;
    wr(8'h06);
    step(3);
    push(1'b0, 2);
    step(4);
    ck(8'(rx_count_reg), 8'h01, "disabled rx count");
    ck(rx_data_reg, 8'h01, "disabled rx overwrite");
    pop(1'b0);
    step(3);
    ck(8'(rx_count_reg), 8'h00, "disabled rx not read out");
  endtask : t_disabled

  // Enabled queue hands out characters in order.
  task t_pop;
    wr(8'h07);
    push(1'b1, 3);
    step(4);
    ck(tx_data_reg, 8'h00, "tx head");
    pop(1'b1);
    step(3);
    ck(tx_data_reg, 8'h01, "tx head after pop");
    ck(8'(tx_count_reg), 8'h02, "tx count after pop");
  endtask : t_pop

  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Free-running clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Watchdog well beyond the roughly 500 cycles the run needs.
  initial begin
    #200us;
    error_cnt++;
    end_sim();
  end

  // Main sequence.
  initial begin
    {rst, enhanced_enable, tx_push, rx_push} = 4'hF;
    {enhanced_enable, tx_push, rx_push, tx_pop, rx_pop} = 5'h00;
    tx_push_data = 8'h00;
    rx_push_data = 8'h00;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    step(1);
    ck(8'({fifo_enable_reg, tx_clear_reg, rx_clear_reg}), 8'h00, "reset values");
    t_enable();
    t_rx_trig();
    t_tx_trig();
    t_gated();
    t_disabled();
    t_pop();
    end_sim();
  end
endmodule : tb
